// *** rtl/txd_defs.svh ***
/*
 * Constants of the texture block decoder: register offsets, field
 * positions, reset values and the fixed modifier tables.
 * Assumes inclusion by bare name from the top module.
 */
`ifndef TXD_DEFS_SVH
`define TXD_DEFS_SVH

`define TXD_ADDR_CTRL 12'h000
`define TXD_ADDR_BLK 12'h010
`define TXD_ADDR_RGBA 12'h020
`define TXD_ADDR_SGN 12'h024
`define TXD_ADDR_STAT 12'h028
`define TXD_ADDR_TAB 12'h100

`define TXD_RST_CTRL 4'h0
`define TXD_RST_WORD 32'h0000_0000

`define TXD_FLIP_BIT 32
`define TXD_OPAC_BIT 33
`define TXD_TC1_MSB 39
`define TXD_TC2_MSB 36

`define TXD_SAT11 17'sh0_03ff
`define TXD_SAT11_NEG 11'h401
`define TXD_SGN_BASE_MIN 8'h80
`define TXD_SGN_BASE_SUB 8'h81
`define TXD_SGN_IDX_TOP 6'h2d

`define TXD_ALPHA_ON 8'hff
`define TXD_LARGE_TAB '{8'h08, 8'h11, 8'h1d, 8'h2a, 8'h3c, 8'h50, 8'h6a, 8'hb7}
`define TXD_SMALL_TAB '{8'h02, 8'h05, 8'h09, 8'h0d, 8'h12, 8'h18, 8'h21, 8'h2f}

`endif

// *** rtl/txd_pkg.sv ***
/*
 * Types of the texture block decoder: texel colour carrier and the
 * mode enumeration. Assumes the constants header for offsets.
 */
package txd_pkg;

  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] g;
    logic [7:0] r;
  } txd_rgba_t;

  typedef enum logic [1:0] {
    MODE_OVF_RED,
    MODE_OVF_GREEN,
    MODE_PLANAR,
    MODE_DIFF
  } txd_mode_t;

endpackage : txd_pkg

// *** rtl/txd_top.sv ***
/*
 * Texture block decoder with an APB register slave. Software loads a
 * 128-bit block and a texel number; the decoder shows the signed
 * two-channel result and, in differential mode only, the punchthrough RGB result of that texel.
 * Assumes an APB master on MCLK and synchronous inputs.
 */
// Summary of operation
// - sixteen block bytes, lowest address first, form two 64-bit words.
// - first word is red, second green, each decoded as signed 11-bit.
// - red base plus signed red delta outside 0..31 selects red overflow mode.
// - else green sum outside 0..31 selects green overflow mode.
// - else blue sum out of range gives planar, otherwise differential.
// - bit 32 splits block into side-by-side or stacked halves.
// - first sub-block base widens 5-bit codes by replicating top bits.
// - second sub-block base adds signed delta, then widens the same way.
// - table selector bits 39..37 for first, 36..34 for second sub-block.
// - opacity flag bit 33 picks one of two fixed table sets.
// - texel index high bit at 16+n, low bit at n, flip-independent.
// - index maps to modifier differently with opacity set or clear.
// - modifier added to each colour component, saturated to 0..255.
// - fixed modifier tables held in hardware, inner entries zero if clear.
// - index 11,10,00,01 give -large,-small,+small,+large; clear zeroes inner.
// - alpha 255, except opacity clear with index 10 gives all zero.
// - signed value base*8 plus modifier*mult*8 (plus modifier alone when mult is 0), saturated to +-1023.
`timescale 1ns/1ps
`include "txd_defs.svh"

module txd_top
  import txd_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output txd_rgba_t TEXEL_RGBA,
  output logic [10:0] TEXEL_RED11,
  output logic [10:0] TEXEL_GREEN11
);

  localparam logic [11:0] A_CTRL = `TXD_ADDR_CTRL;
  localparam logic [11:0] A_BLK = `TXD_ADDR_BLK;
  localparam logic [11:0] A_RGBA = `TXD_ADDR_RGBA;
  localparam logic [11:0] A_SGN = `TXD_ADDR_SGN;
  localparam logic [11:0] A_STAT = `TXD_ADDR_STAT;
  localparam logic [11:0] A_TAB = `TXD_ADDR_TAB;
  localparam logic [7:0] LARGE [8] = `TXD_LARGE_TAB;
  localparam logic [7:0] SMALL [8] = `TXD_SMALL_TAB;

  logic [3:0] tex_ff;
  logic [31:0] blk_ff [4];
  logic [31:0] tab_ff [32];
  logic [31:0] prdata_ff;
  txd_rgba_t rgba_ff;
  logic [10:0] red11_ff;
  logic [10:0] grn11_ff;
  txd_mode_t mode_ff;
  logic flip_ff;
  logic opac_ff;

  // apb decode
  wire aligned = (PADDR[1:0] == 2'h0);
  wire hit_ctrl = aligned & (PADDR == A_CTRL);
  wire hit_blk = aligned & (PADDR[11:4] == A_BLK[11:4]);
  wire hit_tab = aligned & (PADDR[11:7] == A_TAB[11:7]);
  wire hit_rgba = aligned & (PADDR == A_RGBA);
  wire hit_sgn = aligned & (PADDR == A_SGN);
  wire hit_stat = aligned & (PADDR == A_STAT);
  wire hit_ro = hit_rgba | hit_sgn | hit_stat;
  wire mapped = hit_ctrl | hit_blk | hit_tab | hit_ro;
  wire access = PSEL & PENABLE;
  wire setup_rd = PSEL & ~PENABLE & ~PWRITE;
  wire wr_ok = access & PWRITE & mapped & ~hit_ro;

  // zero wait states: read data is captured in the setup cycle
  assign PREADY = 1'b1;
  assign PSLVERR = access & (~mapped | (PWRITE & hit_ro));
  assign PRDATA = prdata_ff;

  wire [31:0] rd_word =
    hit_ctrl ? {28'h000_0000, tex_ff} :
    hit_blk ? blk_ff[PADDR[3:2]] :
    hit_tab ? tab_ff[PADDR[6:2]] :
    hit_rgba ? rgba_ff :
    hit_sgn ? {{5{grn11_ff[10]}}, grn11_ff, {5{red11_ff[10]}}, red11_ff} :
    hit_stat ? {28'h000_0000, opac_ff, flip_ff, mode_ff} :
    32'h0000_0000;

  // block bytes to channel words, first byte most significant
  logic [63:0] chw [2];
  for (genvar c = 0; c < 2; c++) begin : g_word
    for (genvar k = 0; k < 8; k++) begin : g_byte
      assign chw[c][63-8*k -: 8] = blk_ff[2*c+k/4][8*(k%4) +: 8];
    end
  end

  // signed 11-bit decode, one lane per channel
  logic [10:0] nxt_s11 [2];
  for (genvar c = 0; c < 2; c++) begin : g_sgn
    wire [7:0] bcode = chw[c][63:56];
    // the excluded code -128 behaves as -127
    wire signed [7:0] bsat = signed'((bcode == `TXD_SGN_BASE_MIN) ? `TXD_SGN_BASE_SUB : bcode);
    wire [3:0] mul = chw[c][55:52];
    wire [3:0] tsel = chw[c][51:48];
    wire [5:0] sh = `TXD_SGN_IDX_TOP - 6'({tex_ff, 1'b0}) - 6'(tex_ff);
    wire [63:0] shw = chw[c] >> sh;
    wire [2:0] pidx = shw[2:0];
    wire [31:0] tw = tab_ff[{tsel, pidx[2]}];
    wire signed [7:0] modv = signed'(tw[{pidx[1:0], 3'h0} +: 8]);
    wire signed [16:0] prod = 17'(modv) * 17'(signed'({1'b0, mul}));
    wire signed [16:0] term = (mul == 4'h0) ? 17'(modv) : (prod <<< 3);
    wire signed [16:0] sum = (17'(bsat) <<< 3) + term;
    assign nxt_s11[c] = (sum > `TXD_SAT11) ? 11'h3ff :
                        (sum < -`TXD_SAT11) ? `TXD_SAT11_NEG : sum[10:0];
  end

  // punchthrough rgb: mode selection on the red word
  wire [63:0] w = chw[0];
  logic [4:0] c5 [3];
  logic [2:0] d3 [3];
  logic [5:0] sum6 [3];
  logic [2:0] ovf;
  for (genvar i = 0; i < 3; i++) begin : g_mode
    assign c5[i] = w[63-8*i -: 5];
    assign d3[i] = w[58-8*i -: 3];
    // 6-bit sum: bit 5 set means below 0 or above 31
    assign sum6[i] = {1'b0, c5[i]} + {{3{d3[i][2]}}, d3[i]};
    assign ovf[i] = sum6[i][5];
  end

  wire txd_mode_t nxt_mode = ovf[0] ? MODE_OVF_RED :
                             ovf[1] ? MODE_OVF_GREEN :
                             ovf[2] ? MODE_PLANAR : MODE_DIFF;

  wire flip = w[`TXD_FLIP_BIT];
  wire opac = w[`TXD_OPAC_BIT];
  wire msb = w[{1'b1, tex_ff}];
  wire lsb = w[{1'b0, tex_ff}];
  // texel n sits at column n/4, row n%4
  wire sub2 = flip ? tex_ff[1] : tex_ff[3];
  wire [2:0] tc = sub2 ? w[`TXD_TC2_MSB -: 3] : w[`TXD_TC1_MSB -: 3];
  wire signed [8:0] lg9 = signed'({1'b0, LARGE[tc]});
  // inner entries vanish when opacity is clear
  wire signed [8:0] sm9 = opac ? signed'({1'b0, SMALL[tc]}) : 9'sh000;
  wire signed [8:0] mod9 = msb ? (lsb ? -lg9 : -sm9) : (lsb ? lg9 : sm9);
  wire punch = ~opac & msb & ~lsb;

  logic [7:0] col [3];
  logic [7:0] base8 [3];
  for (genvar i = 0; i < 3; i++) begin : g_col
    wire [4:0] c5s = sub2 ? sum6[i][4:0] : c5[i];
    assign base8[i] = {c5s, c5s[4:2]};
    wire signed [9:0] s10 = signed'({2'h0, base8[i]}) + 10'(mod9);
    wire [7:0] sat = s10[9] ? 8'h00 : (s10[8] ? 8'hff : s10[7:0]);
    // other modes need colour arithmetic this block does not carry
    assign col[i] = ((nxt_mode == MODE_DIFF) && !punch) ? sat : 8'h00;
  end

  wire txd_rgba_t nxt_rgba = '{a: punch ? 8'h00 : `TXD_ALPHA_ON,
                               b: col[2], g: col[1], r: col[0]};

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      tex_ff <= `TXD_RST_CTRL;
      for (int i = 0; i < 4; i++) blk_ff[i] <= `TXD_RST_WORD;
      for (int i = 0; i < 32; i++) tab_ff[i] <= `TXD_RST_WORD;
    end else if (wr_ok) begin
      if (hit_ctrl) tex_ff <= PWDATA[3:0];
      if (hit_blk) blk_ff[PADDR[3:2]] <= PWDATA;
      if (hit_tab) tab_ff[PADDR[6:2]] <= PWDATA;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_ff <= `TXD_RST_WORD;
    end else if (setup_rd) begin
      prdata_ff <= rd_word;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rgba_ff <= '0;
      red11_ff <= 11'h000;
      grn11_ff <= 11'h000;
      mode_ff <= MODE_OVF_RED;
      flip_ff <= 1'b0;
      opac_ff <= 1'b0;
    end else begin
      rgba_ff <= nxt_rgba;
      red11_ff <= nxt_s11[0];
      grn11_ff <= nxt_s11[1];
      mode_ff <= nxt_mode;
      flip_ff <= flip;
      opac_ff <= opac;
    end
  end

  assign TEXEL_RGBA = rgba_ff;
  assign TEXEL_RED11 = red11_ff;
  assign TEXEL_GREEN11 = grn11_ff;

  a_mode_red: assert property (@(posedge MCLK) disable iff (!RST_N)
    ovf[0] |=> mode_ff == MODE_OVF_RED) else $error("red overflow mode not taken");

  a_mode_green: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!ovf[0] && ovf[1]) |=> mode_ff == MODE_OVF_GREEN) else $error("green overflow mode not taken");

  a_mode_rest: assert property (@(posedge MCLK) disable iff (!RST_N)
    !ovf[0] && !ovf[1] |=> mode_ff == ($past(ovf[2]) ? MODE_PLANAR : MODE_DIFF))
    else $error("planar or differential mode wrong");

  a_punch_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    punch |=> TEXEL_RGBA == 32'h0000_0000) else $error("punchthrough texel not all zero");

  a_alpha_full: assert property (@(posedge MCLK) disable iff (!RST_N)
    !punch |=> TEXEL_RGBA.a == 8'hff) else $error("alpha not 255");

  a_inner_zero: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && !opac && !msb && !lsb) |=>
      TEXEL_RGBA.r == $past(base8[0]) && TEXEL_RGBA.b == $past(base8[2]))
    else $error("inner modifier not zero with opacity clear");

  a_sat_up: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && !msb && opac) |=> TEXEL_RGBA.g >= $past(base8[1]))
    else $error("positive modifier lowered colour");

  a_sgn_range: assert property (@(posedge MCLK) disable iff (!RST_N)
    ##1 TEXEL_RED11 != 11'h400 && TEXEL_GREEN11 != 11'h400) else $error("signed result below -1023");

  a_word_order: assert property (@(posedge MCLK) disable iff (!RST_N)
    chw[1][63:56] == blk_ff[2][7:0] && chw[0][7:0] == blk_ff[1][31:24])
    else $error("channel word byte order wrong");

  // bus writes land in the addressed word only
  a_blk_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (access && PWRITE && hit_blk) |=> blk_ff[$past(PADDR[3:2])] == $past(PWDATA))
    else $error("block word not written");

  a_tab_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (access && PWRITE && hit_tab) |=> tab_ff[$past(PADDR[6:2])] == $past(PWDATA))
    else $error("signed table word not written");

  a_tex_write: assert property (@(posedge MCLK) disable iff (!RST_N)
    (access && PWRITE && hit_ctrl) |=> tex_ff == $past(PWDATA[3:0]))
    else $error("texel number not written");

  // bases rebuilt from raw fields, so a wrong field position shows here
  a_base_first: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && !sub2 && !opac && !msb && !lsb) |=>
      TEXEL_RGBA[23:0] == $past({w[47:43], w[47:45], w[55:51], w[55:53], w[63:59], w[63:61]}))
    else $error("first sub-block base not widened");

  a_base_second: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && sub2 && !opac && !msb && !lsb) |=>
      TEXEL_RGBA.r[7:3] == $past(5'(w[63:59] + {{2{w[58]}}, w[58:56]})) &&
      TEXEL_RGBA.r[2:0] == TEXEL_RGBA.r[7:5]) else $error("second sub-block base wrong");

  // green base kept below 64 so the small modifier cannot saturate
  a_flip_upper: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && flip && !tex_ff[1] && opac && !msb && !lsb && w[55:54] == 2'h0) |=>
      TEXEL_RGBA.g == $past({w[55:51], w[55:53]} + SMALL[w[`TXD_TC1_MSB -: 3]])) else $error("upper rows not first sub-block");

  a_large_pick: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && opac && !msb && lsb && base8[1] < 8'h48) |=>
      TEXEL_RGBA.g == $past(base8[1] + LARGE[tc])) else $error("large positive modifier wrong");

  a_small_pick: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && opac && !msb && !lsb && base8[1] < 8'hd0) |=>
      TEXEL_RGBA.g == $past(base8[1] + SMALL[tc])) else $error("small positive modifier wrong");

  a_large_neg: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && msb && lsb && base8[0] >= 8'hb7) |=>
      TEXEL_RGBA.r == $past(base8[0] - LARGE[tc])) else $error("large negative modifier wrong");

  a_sat_low: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && msb && lsb && base8[2] < LARGE[tc]) |=>
      TEXEL_RGBA.b == 8'h00) else $error("colour not clamped at zero");

  a_sat_high: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode == MODE_DIFF && opac && !msb && lsb && base8[0] > 8'hff - LARGE[tc]) |=>
      TEXEL_RGBA.r == 8'hff) else $error("colour not clamped at 255");

  a_opac_alpha: assert property (@(posedge MCLK) disable iff (!RST_N)
    opac |=> TEXEL_RGBA.a == 8'hff) else $error("opaque texel lost alpha");

  // limitation: colour of the other modes stays dark, their arithmetic is absent
  a_other_dark: assert property (@(posedge MCLK) disable iff (!RST_N)
    (nxt_mode != MODE_DIFF) |=> TEXEL_RGBA[23:0] == 24'h00_0000) else $error("colour shown outside differential");

  a_sgn_pass: assert property (@(posedge MCLK) disable iff (!RST_N)
    (g_sgn[0].sum <= `TXD_SAT11 && g_sgn[0].sum >= -`TXD_SAT11) |=>
      TEXEL_RED11 == $past(g_sgn[0].sum[10:0])) else $error("in-range signed value altered");

  a_sgn_clamp: assert property (@(posedge MCLK) disable iff (!RST_N)
    (g_sgn[1].sum < -`TXD_SAT11) |=> TEXEL_GREEN11 == `TXD_SAT11_NEG) else $error("signed value not clamped low");

endmodule : txd_top

// *** sim/txd_blk_mem.sv ***
/*
 * Texture fetch memory model: holds one 16-byte block and hands it out
 * as 32-bit words. Assumes the bench fills it and moves the words over APB.
 */
`timescale 1ns/1ps
module txd_blk_mem;
  logic [7:0] mem [16];

  // byte 0 is the most significant byte of the red word, byte 8 of the green word
  task automatic put(input logic [63:0] red_w, input logic [63:0] grn_w);
    for (int i = 0; i < 8; i++) begin
      mem[i] = red_w[63-8*i -: 8];
      mem[8+i] = grn_w[63-8*i -: 8];
    end
  endtask : put

  // lowest address in the low lane, as the block registers expect
  function automatic logic [31:0] word(input int k);
    return {mem[4*k+3], mem[4*k+2], mem[4*k+1], mem[4*k]};
  endfunction : word
endmodule : txd_blk_mem

// *** sim/txd_top_tb.sv ***
/*
 * Testbench of the texture block decoder: APB tasks and directed decodes.
 * Assumes the block memory model and the design files are compiled first.
 */
`timescale 1ns/1ps
module txd_top_tb import txd_pkg::*;;
  logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e;
  txd_rgba_t rgba;
  logic [10:0] red11, grn11;
  int num_errors = 0, checked = 0;
  int em[4] = '{0, 0, 1, 2};
  logic [63:0] mw[4] = '{64'hf900_0000_0000_0000, 64'h0400_0000_0000_0000, 64'h00f9_0000_0000_0000,
    64'h0000_f900_0000_0000};

  txd_blk_mem mem_u();
  txd_top dut_u(.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TEXEL_RGBA(rgba),
    .TEXEL_RED11(red11), .TEXEL_GREEN11(grn11));

  initial begin
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // no wait count assumed: only the bound cuts a missing pready short
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) begin
      num_errors++;
      end_sim();
    end
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask : rdc

  task automatic load(input logic [63:0] red_w, input logic [63:0] grn_w, input int n);
    mem_u.put(red_w, grn_w);
    for (int k = 0; k < 4; k++) apb(1'b1, 12'h010 + 12'(4 * k), mem_u.word(k));
    apb(1'b1, 12'h000, 32'(n));
  endtask : load

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(12'h028, 32'h0000_0003);
    rdc(12'h020, 32'hff00_0000);
    rdc(12'h168, 32'h0000_0000);
    $display("reset test done");
    load(64'he422_1842_0000_0001, 64'h0, 0);
    rdc(12'h020, 32'hff35_3eff);
    chk(rgba, 32'hff35_3eff);
    rdc(12'h028, 32'h0000_000b);
    apb(1'b1, 12'h000, 32'h0000_0008);
    rdc(12'h020, 32'hff1a_33c8);
    load(64'he422_1843_0000_0000, 64'h0, 2);
    rdc(12'h020, 32'hff1a_33c8);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rdc(12'h020, 32'hff21_2af0);
    $display("differential test done");
    load(64'he422_1840_0003_0002, 64'h0, 0);
    rdc(12'h020, 32'h0000_0000);
    apb(1'b1, 12'h000, 32'h0000_0001);
    rdc(12'h020, 32'hff00_04ca);
    apb(1'b1, 12'h000, 32'h0000_0008);
    rdc(12'h020, 32'hff18_31c6);
    $display("opacity test done");
    for (int i = 0; i < 4; i++) begin
      load(mw[i], 64'h0, 0);
      rdc(12'h028, 32'(em[i]));
    end
    $display("mode test done");
    apb(1'b1, 12'h168, 32'hf600_0000);
    rdc(12'h168, 32'hf600_0000);
    load(64'h3c0d_6000_0000_0000, 64'h81fd_6000_0000_0000, 0);
    rdc(12'h024, 32'hfc01_01d6);
    chk({21'h0, red11}, 32'h0000_01d6);
    chk({21'h0, grn11}, 32'h0000_0401);
    $display("signed test done");
    apb(1'b0, 12'h200, 32'h0000_0000);
    chk({q[31:1], e}, 32'h0000_0001);
    apb(1'b1, 12'h020, 32'h1234_5678);
    chk({31'h0, e}, 32'h0000_0001);
    $display("refusal test done");
    end_sim();
  end
endmodule : txd_top_tb
